// ### rtl/pio_pkg.sv
// Purpose: Shared constants and carriers for the parallel I/O port bank
// Assumes: 16-bit register bus with byte addresses as printed
// Notes: Port A and the extra port C bits exist only on the large variant
package pio_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int SYNC_W = 48;

   localparam logic [15:0] OFS_DIR_A = 16'h02c0;
   localparam logic [15:0] OFS_PINS_A = 16'h02c2;
   localparam logic [15:0] OFS_LATCH_A = 16'h02c4;
   localparam logic [15:0] OFS_DIR_B = 16'h02c6;
   localparam logic [15:0] OFS_PINS_B = 16'h02c8;
   localparam logic [15:0] OFS_LATCH_B = 16'h02cb;
   localparam logic [15:0] OFS_DIR_C = 16'h02cc;
   localparam logic [15:0] OFS_PINS_C = 16'h02ce;
   localparam logic [15:0] OFS_LATCH_C = 16'h02d0;
   localparam logic [15:0] OFS_ANALOG_CFG = 16'h02a0;

   localparam logic [15:0] IMPL_A = 16'hf6c0;
   localparam logic [15:0] IMPL_B = 16'hffff;
   localparam logic [15:0] IMPL_C_SMALL = 16'he006;
   localparam logic [15:0] IMPL_C_LARGE = 16'he01e;
   localparam logic [15:0] NONE_MASK = 16'h0000;

   localparam logic [15:0] DIR_RST_A = 16'hf6c0;
   localparam logic [15:0] DIR_RST_B = 16'hffff;
   localparam logic [15:0] DIR_RST_C_SMALL = 16'he006;
   localparam logic [15:0] DIR_RST_C_LARGE = 16'he01e;
   localparam logic [15:0] LATCH_RST = 16'h0000;
   localparam logic [15:0] ANALOG_RST = 16'h0000;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   typedef logic [DATA_W-1:0] word_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      word_t wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      word_t en;
      word_t active;
      word_t out;
   } periph_t;

   typedef struct packed {
      word_t out;
      word_t oe;
   } pad_drive_t;

   typedef struct packed {
      word_t dir;
      word_t lat;
   } port_regs_t;
endpackage

// ### rtl/pio_sync2.sv
// Purpose: Two-flop level synchroniser for pad inputs
// Assumes: Single clock, clock enable freezes both stages
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pio_sync2 #(
   parameter int W = 48
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   if (W < 1) begin : g_bad_width
      $error("pio_sync2: width must be at least one");
   end

   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.meta = d;
         s_d.stable = s_q.meta;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;
endmodule

// ### rtl/parallel_io_port_bank.sv
// Purpose: Parallel I/O ports A, B and C with peripheral pin sharing
// Assumes: Pads and peripherals synchronous to core_clk; plain register port
// Notes: Pad drive is registered, so a peripheral change reaches the pad one cycle on, a register write two cycles on
//
// Functional notes
// - Driving peripheral disables port driver, pin readable
// - Idle enabled peripheral leaves pin to port
// - Each pin has direction, level, latch registers
// - Direction one is input, zero drives latch
// - All pins come out of reset as inputs
// - Latch reads return latch, writes update latch
// - Level reads return pins, writes update latch
// - Unimplemented bits read back as zero
// - Peripheral wins pad data and enable muxes
// - Input-only shared pins get no output override
// - Analog configured pins read zero on level
// - Digital input pins are not routed to converter
// - Port A implements 15-12, 10, 9, 7, 6
// - Small variant has no port A at all
// - Port B implements all sixteen bits
// - Port C bit set depends on variant
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module parallel_io_port_bank #(
   parameter int unsigned LARGE_VARIANT = 1,
   parameter logic [15:0] OVR_MASK_A = 16'hffff,
   parameter logic [15:0] OVR_MASK_B = 16'hffff,
   parameter logic [15:0] OVR_MASK_C = 16'hffff
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire pio_pkg::bus_req_t bus_req,
   output pio_pkg::word_t rd_data,
   input wire pio_pkg::word_t pad_in_a,
   input wire pio_pkg::word_t pad_in_b,
   input wire pio_pkg::word_t pad_in_c,
   input wire pio_pkg::periph_t periph_a,
   input wire pio_pkg::periph_t periph_b,
   input wire pio_pkg::periph_t periph_c,
   output pio_pkg::pad_drive_t pad_a,
   output pio_pkg::pad_drive_t pad_b,
   output pio_pkg::pad_drive_t pad_c,
   output pio_pkg::word_t adc_route
);
   localparam logic [15:0] IMPL_A_V = (LARGE_VARIANT == 1) ?
      pio_pkg::IMPL_A : pio_pkg::NONE_MASK;
   localparam logic [15:0] IMPL_C_V = (LARGE_VARIANT == 1) ?
      pio_pkg::IMPL_C_LARGE : pio_pkg::IMPL_C_SMALL;
   localparam logic [15:0] DIR_RST_A_V = pio_pkg::DIR_RST_A & IMPL_A_V;
   localparam logic [15:0] DIR_RST_C_V = (LARGE_VARIANT == 1) ?
      pio_pkg::DIR_RST_C_LARGE : pio_pkg::DIR_RST_C_SMALL;

   if (LARGE_VARIANT > 1) begin : g_bad_variant
      $error("parallel_io_port_bank: LARGE_VARIANT must be 0 or 1");
   end

   typedef struct packed {
      pio_pkg::port_regs_t a;
      pio_pkg::port_regs_t b;
      pio_pkg::port_regs_t c;
      pio_pkg::word_t analog;
      pio_pkg::word_t rdata;
      pio_pkg::pad_drive_t pa;
      pio_pkg::pad_drive_t pb;
      pio_pkg::pad_drive_t pc;
      pio_pkg::word_t adc;
   } state_t;

   localparam state_t STATE_RST = '{
      a: '{dir: DIR_RST_A_V, lat: pio_pkg::LATCH_RST},
      b: '{dir: pio_pkg::DIR_RST_B, lat: pio_pkg::LATCH_RST},
      c: '{dir: DIR_RST_C_V, lat: pio_pkg::LATCH_RST},
      analog: pio_pkg::ANALOG_RST,
      rdata: pio_pkg::RDATA_RST,
      pa: '{out: pio_pkg::LATCH_RST, oe: pio_pkg::NONE_MASK},
      pb: '{out: pio_pkg::LATCH_RST, oe: pio_pkg::NONE_MASK},
      pc: '{out: pio_pkg::LATCH_RST, oe: pio_pkg::NONE_MASK},
      adc: pio_pkg::NONE_MASK
   };

   state_t s_q;
   state_t s_d;
   logic [pio_pkg::SYNC_W-1:0] pads_sync;
   pio_pkg::word_t lvl_a;
   pio_pkg::word_t lvl_b;
   pio_pkg::word_t lvl_c;

   // Masked store keeps absent bits at zero without per-read masking
   function automatic pio_pkg::word_t masked_write(
      input pio_pkg::word_t wdata,
      input pio_pkg::word_t impl
   );
      masked_write = wdata & impl;
   endfunction

   function automatic pio_pkg::pad_drive_t pad_mux(
      input pio_pkg::port_regs_t regs,
      input pio_pkg::periph_t per,
      input pio_pkg::word_t impl,
      input pio_pkg::word_t ovr
   );
      pio_pkg::word_t own;
      own = per.en & per.active & ovr & impl;
      pad_mux.out = (own & per.out) | (~own & regs.lat & impl);
      pad_mux.oe = own | (~own & ~regs.dir & impl);
   endfunction

   function automatic logic hit(
      input logic [pio_pkg::ADDR_W-1:0] addr,
      input logic [pio_pkg::ADDR_W-1:0] ofs
   );
      hit = (addr == ofs);
   endfunction

   pio_sync2 #(
      .W(pio_pkg::SYNC_W)
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .d({pad_in_a, pad_in_b, pad_in_c}),
      .q(pads_sync)
   );

   assign lvl_a = pads_sync[47:32] & IMPL_A_V;
   assign lvl_b = pads_sync[31:16] & pio_pkg::IMPL_B & ~s_q.analog;
   assign lvl_c = pads_sync[15:0] & IMPL_C_V;

   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.rdata = pio_pkg::RDATA_RST;
         if (bus_req.wr) begin
            if (hit(bus_req.addr, pio_pkg::OFS_DIR_A)) begin
               s_d.a.dir = masked_write(bus_req.wdata, IMPL_A_V);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_PINS_A) ||
                hit(bus_req.addr, pio_pkg::OFS_LATCH_A)) begin
               s_d.a.lat = masked_write(bus_req.wdata, IMPL_A_V);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_DIR_B)) begin
               s_d.b.dir = masked_write(bus_req.wdata, pio_pkg::IMPL_B);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_PINS_B) ||
                hit(bus_req.addr, pio_pkg::OFS_LATCH_B)) begin
               s_d.b.lat = masked_write(bus_req.wdata, pio_pkg::IMPL_B);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_DIR_C)) begin
               s_d.c.dir = masked_write(bus_req.wdata, IMPL_C_V);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_PINS_C) ||
                hit(bus_req.addr, pio_pkg::OFS_LATCH_C)) begin
               s_d.c.lat = masked_write(bus_req.wdata, IMPL_C_V);
            end
            if (hit(bus_req.addr, pio_pkg::OFS_ANALOG_CFG)) begin
               s_d.analog = masked_write(bus_req.wdata, pio_pkg::IMPL_B);
            end
         end
         if (bus_req.rd) begin
            case (bus_req.addr)
               pio_pkg::OFS_DIR_A: begin
                  s_d.rdata = s_q.a.dir;
               end
               pio_pkg::OFS_PINS_A: begin
                  s_d.rdata = lvl_a;
               end
               pio_pkg::OFS_LATCH_A: begin
                  s_d.rdata = s_q.a.lat;
               end
               pio_pkg::OFS_DIR_B: begin
                  s_d.rdata = s_q.b.dir;
               end
               pio_pkg::OFS_PINS_B: begin
                  s_d.rdata = lvl_b;
               end
               pio_pkg::OFS_LATCH_B: begin
                  s_d.rdata = s_q.b.lat;
               end
               pio_pkg::OFS_DIR_C: begin
                  s_d.rdata = s_q.c.dir;
               end
               pio_pkg::OFS_PINS_C: begin
                  s_d.rdata = lvl_c;
               end
               pio_pkg::OFS_LATCH_C: begin
                  s_d.rdata = s_q.c.lat;
               end
               pio_pkg::OFS_ANALOG_CFG: begin
                  s_d.analog = s_d.analog;
                  s_d.rdata = s_q.analog;
               end
               default: begin
                  s_d.rdata = pio_pkg::RDATA_RST;
               end
            endcase
         end
         s_d.pa = pad_mux(s_q.a, periph_a, IMPL_A_V, OVR_MASK_A);
         s_d.pb = pad_mux(s_q.b, periph_b, pio_pkg::IMPL_B, OVR_MASK_B);
         s_d.pc = pad_mux(s_q.c, periph_c, IMPL_C_V, OVR_MASK_C);
         s_d.adc = s_q.analog;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rdata;
   assign pad_a = s_q.pa;
   assign pad_b = s_q.pb;
   assign pad_c = s_q.pc;
   assign adc_route = s_q.adc;
endmodule

// ### bench/pio_pad_model.sv
// Purpose: Port B pad world, pad cell plus outside driver
// Assumes: Outside driver holds ext wherever the pad is off
// Notes: Pad cell wins where enabled, no contention model
`timescale 1ns/1ps
module pio_pad_model (
   input wire pio_pkg::pad_drive_t pad,
   input wire pio_pkg::word_t ext,
   output pio_pkg::word_t lvl
);
   assign lvl = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule

// ### bench/pio_props.sv
// Purpose: Checker for port B drive, reads and routing
// Assumes: Large variant, override masks all ones
// Notes: Pad drive of ports A and C is not watched
`timescale 1ns/1ps
module pio_props (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire pio_pkg::bus_req_t bus_req,
   input wire pio_pkg::word_t rd_data,
   input wire pio_pkg::word_t pad_in_b,
   input wire pio_pkg::periph_t periph_b,
   input wire pio_pkg::pad_drive_t pad_b,
   input wire pio_pkg::word_t adc_route
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   pio_pkg::word_t own;
   logic wr_lat;
   logic rd_pin;
   assign own = periph_b.en & periph_b.active;
   // Level and latch offsets both land in the latch
   assign wr_lat = ce && bus_req.wr
      && (bus_req.addr == pio_pkg::OFS_LATCH_B || bus_req.addr == pio_pkg::OFS_PINS_B);
   assign rd_pin = ce && bus_req.rd && bus_req.addr == pio_pkg::OFS_PINS_B;
   property p_own;
      ce |=> ((pad_b.oe & $past(own)) == $past(own))
         && (((pad_b.out ^ $past(periph_b.out)) & $past(own)) == '0);
   endproperty
   property p_dir;
      ce && bus_req.wr && bus_req.addr == pio_pkg::OFS_DIR_B ##1 ce && !bus_req.wr
         |=> pad_b.oe == (~$past(bus_req.wdata, 2) | $past(own));
   endproperty
   property p_lat;
      wr_lat ##1 ce && !bus_req.wr |=> ((pad_b.out ^ $past(bus_req.wdata, 2)) & ~$past(own)) == '0;
   endproperty
   property p_ana;
      rd_pin |=> (rd_data & adc_route) == '0;
   endproperty
   property p_route;
      ce && bus_req.wr && bus_req.addr == pio_pkg::OFS_ANALOG_CFG ##1 ce
         |=> adc_route == $past(bus_req.wdata, 2);
   endproperty
   property p_absent;
      ce && bus_req.rd && bus_req.addr == pio_pkg::OFS_DIR_C
         |=> (rd_data & ~pio_pkg::IMPL_C_LARGE) == '0;
   endproperty
   property p_sync;
      ($stable(pad_in_b) && ce) [*3] ##0 rd_pin |=> rd_data == ($past(pad_in_b) & ~adc_route);
   endproperty
   property p_rst;
      $rose(nrst) && own == '0 |=> pad_b.oe == '0;
   endproperty
   a_own: assert property (p_own) else $error("pad not owned");
   a_dir: assert property (p_dir) else $error("pad enable wrong");
   a_lat: assert property (p_lat) else $error("pad data wrong");
   a_ana: assert property (p_ana) else $error("analog bit read");
   a_route: assert property (p_route) else $error("route wrong");
   a_absent: assert property (p_absent) else $error("absent bit read");
   a_sync: assert property (p_sync) else $error("level read wrong");
   a_rst: assert property (p_rst) else $error("pad driven after reset");
   c_own: cover property (ce && own != '0);
   c_lat: cover property (wr_lat);
   c_ana: cover property (rd_pin && adc_route != '0);
endmodule
bind parallel_io_port_bank pio_props i_pio_props (.core_clk(core_clk), .nrst(nrst), .ce(ce),
   .bus_req(bus_req), .rd_data(rd_data), .pad_in_b(pad_in_b), .periph_b(periph_b),
   .pad_b(pad_b), .adc_route(adc_route));

// ### bench/tb.sv
// Purpose: Self-checking bench for the port bank
// Assumes: Large variant, port B looped through the pad model
// Notes: Ports A and C pads and peripherals are held idle
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   pio_pkg::bus_req_t bus_req = '0;
   pio_pkg::periph_t periph_b = '0;
   pio_pkg::word_t ext_b = '0;
   pio_pkg::word_t pad_in_b;
   pio_pkg::word_t rd_data;
   pio_pkg::word_t adc_route;
   pio_pkg::pad_drive_t pad_b;
   int mismatches = 0;
   int n_tests = 0;
   always #2 core_clk = ~core_clk;
   parallel_io_port_bank i_parallel_io_port_bank (.core_clk(core_clk), .nrst(nrst),
      .ce(ce), .bus_req(bus_req), .rd_data(rd_data), .pad_in_a('0), .pad_in_b(pad_in_b),
      .pad_in_c('0), .periph_a('0), .periph_b(periph_b), .periph_c('0), .pad_a(),
      .pad_b(pad_b), .pad_c(), .adc_route(adc_route));
   pio_pad_model i_pio_pad_model (.pad(pad_b), .ext(ext_b), .lvl(pad_in_b));
   task automatic check(input pio_pkg::word_t seen, input pio_pkg::word_t exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input pio_pkg::word_t a, input pio_pkg::word_t d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input pio_pkg::word_t a, input pio_pkg::word_t exp);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 check(rd_data, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic t_reset;
      rd(pio_pkg::OFS_DIR_A, 16'hf6c0);
      rd(pio_pkg::OFS_DIR_B, 16'hffff);
      rd(pio_pkg::OFS_DIR_C, 16'he01e);
      rd(pio_pkg::OFS_LATCH_B, 16'h0000);
      check(pad_b.oe, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_regs;
      @(posedge core_clk);
      ext_b <= 16'hf0f0;
      wr(pio_pkg::OFS_DIR_B, 16'h00ff);
      wr(pio_pkg::OFS_LATCH_B, 16'ha5c3);
      settle(2);
      check(pad_b.oe, 16'hff00);
      check(pad_b.out, 16'ha5c3);
      rd(pio_pkg::OFS_LATCH_B, 16'ha5c3);
      wr(pio_pkg::OFS_PINS_B, 16'h1234);
      rd(pio_pkg::OFS_LATCH_B, 16'h1234);
      settle(4);
      rd(pio_pkg::OFS_PINS_B, 16'h12f0);
      wr(pio_pkg::OFS_LATCH_C, 16'hffff);
      rd(pio_pkg::OFS_LATCH_C, 16'he01e);
      wr(16'h02d2, 16'hffff);
      rd(16'h02d2, 16'h0000);
      $display("test registers done");
   endtask
   task automatic t_periph;
      wr(pio_pkg::OFS_DIR_B, 16'h0000);
      wr(pio_pkg::OFS_LATCH_B, 16'h0000);
      @(posedge core_clk);
      periph_b <= '{en: 16'hffff, active: 16'h000f, out: 16'h0005};
      settle(4);
      check(pad_b.oe, 16'hffff);
      check(pad_b.out, 16'h0005);
      rd(pio_pkg::OFS_PINS_B, 16'h0005);
      wr(pio_pkg::OFS_DIR_B, 16'hffff);
      settle(2);
      check(pad_b.oe, 16'h000f);
      @(posedge core_clk);
      periph_b <= '0;
      $display("test peripheral done");
   endtask
   task automatic t_analog;
      @(posedge core_clk);
      ext_b <= 16'hffff;
      wr(pio_pkg::OFS_DIR_B, 16'hffff);
      wr(pio_pkg::OFS_ANALOG_CFG, 16'h00f0);
      settle(4);
      check(adc_route, 16'h00f0);
      rd(pio_pkg::OFS_PINS_B, 16'hff0f);
      wr(pio_pkg::OFS_ANALOG_CFG, 16'h0000);
      settle(2);
      check(adc_route, 16'h0000);
      // Clock enable low must drop the write
      @(posedge core_clk);
      ce <= 1'b0;
      wr(pio_pkg::OFS_LATCH_B, 16'hffff);
      @(posedge core_clk);
      ce <= 1'b1;
      rd(pio_pkg::OFS_LATCH_B, 16'h0000);
      $display("test analog done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_periph();
      t_analog();
      results();
   end
endmodule
